// File: design/scsd_decoder.sv
// Command octet decoder and status octet shifter of the serial interface
`timescale 1ns/1ps
`default_nettype none
`include "scsd_regs.svh"

// What this block does
// - Middle four command bits give register address or fast command selector.
// - Writes to read-only registers are refused; host then raises chip select.
// - Every register address is readable; no read is rejected.
// - Low two bits: 00 fast, 01 static read, 10 write, 11 incremental read.
// - Command type holds for the whole chip-select-low period.
// - Code 1010 sets conversion mode to 11, starting or restarting conversion.
// - Code 1011 sets mode 10 standby; code 1100 sets mode 00 shutdown.
// - Code 1101 clears the first configuration register for full shutdown.
// - Code 1110 returns every register to its default value.
// - Power-on flag reads 1 after full reset, 0 after power-on reset.
// - Conversion data register defaults only through the full reset command.
// - Fast codes 0xxx, 100x and 1111 are ignored.
// - Fast command acts once the command octet is fully shifted in.
// - After a fast command octet the output stays released until chip select rises.
// - Fast commands run only while quick command enable, reset 1, is set.
// - Status octet shifts out with two leading zeros, driven low at select fall.
// - On match status bits 5:4 are chip address, bit 3 inverts address bit 0.
// - Address mismatch ignores command and releases the output.
// - Status bits 2,1,0 are data ready, checksum error, power-on flags.
// - Status flags clear after a complete status octet is shifted out.
// - Flags are captured once the address is recognised; later events wait.
// - After status, output released for fast and write, read data for reads.
// - Chip select rise aborts the transaction and idles the serial logic.
// - Sample on rising serial clock, change output on falling; both idle levels.
module scsd_decoder
    import scsd_pkg::*;
#(
    parameter logic [1:0] CHIP_ADDR = `SCSD_CHIP_ADDR_RST
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic read_data_bit,
    output logic sdo,
    output logic sdo_oe_n,
    input wire scsd_events_t events,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wr_data,
    input wire logic qce_wr,
    input wire logic qce_wr_data,
    output logic [7:0] first_config_register,
    output logic quick_command_enable,
    output logic data_ready_flag,
    output logic config_checksum_error_flag,
    output logic power_on_flag,
    output logic conv_restart,
    output logic full_reset,
    output scsd_access_t access
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [7:0] status_byte(input logic [2:0] snap);
        status_byte = {2'b00, CHIP_ADDR, ~CHIP_ADDR[0], snap};
    endfunction : status_byte

    function automatic logic read_only(input logic [3:0] addr);
        read_only = (addr == `SCSD_RO_ADDR_FIRST) || (addr == `SCSD_RO_ADDR_LAST);
    endfunction : read_only

    scsd_link_t l;
    scsd_link_t next_l;
    scsd_event_t e;
    scsd_event_t next_e;
    scsd_out_t o;
    scsd_out_t next_o;
    scsd_core_t c;
    scsd_core_t next_c;
    logic link_reset;
    logic [7:0] status_now;

    // Status octet built from the flags captured at the second rising sck
    assign status_now = status_byte(l.snap);

    // Chip select high holds the whole serial side idle
    assign link_reset = rst | cs_n;

    // ----------------------------------------------------------------
    // Serial side, sampling on rising sck
    // ----------------------------------------------------------------
    always_comb begin
        next_l = l;
        next_e = e;
        next_l.fsync1 = c.flags;
        next_l.fsync2 = l.fsync1;
        if (l.cnt < `SCSD_CMD_BITS) begin
            next_l.shift = {l.shift[6:0], sdi};
            next_l.cnt = l.cnt + 4'h1;
        end
        if (l.cnt == `SCSD_ADDR_DONE) begin
            // Flags are sampled at rise one and settle for a full sck period
            next_l.snap = l.fsync1;
            if ({l.shift[0], sdi} != CHIP_ADDR) begin
                next_l.hiz = 1'b1;
            end
        end
        // Type is fixed from here until chip select rises
        if (l.cnt == `SCSD_CMD_LAST && !l.hiz) begin
            next_e.cmd = {l.shift[6:0], sdi};
            next_e.snap = l.snap;
            next_e.tgl = ~e.tgl;
            next_l.is_read = sdi;
            if (!sdi) begin
                next_l.hiz = 1'b1;
            end
        end
    end

    always_ff @(posedge sck or posedge link_reset) begin
        if (link_reset) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            e <= '0;
        end else begin
            e <= next_e;
        end
    end

    // ----------------------------------------------------------------
    // Serial output, changing on falling sck
    // ----------------------------------------------------------------
    always_comb begin
        next_o.oe_n = l.hiz;
        if (l.cnt < `SCSD_CMD_BITS) begin
            next_o.sdo = status_now[3'h7 - l.cnt[2:0]];
        end else begin
            next_o.sdo = l.is_read & read_data_bit;
        end
    end

    always_ff @(negedge sck or posedge link_reset) begin
        if (link_reset) begin
            o <= '0;
        end else begin
            o <= next_o;
        end
    end

    // Driven low from the select fall, released while select is high
    assign sdo = o.sdo;
    assign sdo_oe_n = cs_n | o.oe_n;

    // ----------------------------------------------------------------
    // Master clock side
    // ----------------------------------------------------------------
    always_comb begin
        next_c = c;
        next_c.tsync1 = e.tgl;
        next_c.tsync2 = c.tsync1;
        next_c.tsync3 = c.tsync2;
        next_c.conv_restart = 1'b0;
        next_c.full_reset = 1'b0;
        next_c.acc.start = 1'b0;
        next_c.acc.refused = 1'b0;
        if (cfg_wr) begin
            next_c.cfg = cfg_wr_data;
        end
        if (qce_wr) begin
            next_c.qce = qce_wr_data;
        end
        if (c.tsync2 != c.tsync3) begin
            // Command octet and snapshot are held stable on the serial side
            next_c.flags = c.flags & ~e.snap;
            if (e.cmd[1:0] == `SCSD_TYPE_FAST) begin
                if (c.qce) begin
                    case (e.cmd[5:2])
                        `SCSD_FAST_CONV_START: begin
                            next_c.cfg[1:0] = `SCSD_MODE_CONVERT;
                            next_c.conv_restart = 1'b1;
                        end
                        `SCSD_FAST_STANDBY: begin
                            next_c.cfg[1:0] = `SCSD_MODE_STANDBY;
                        end
                        `SCSD_FAST_SHUTDOWN: begin
                            next_c.cfg[1:0] = `SCSD_MODE_SHUTDOWN;
                        end
                        `SCSD_FAST_FULL_SHUTDOWN: begin
                            next_c.cfg = `SCSD_CFG0_FULL_SHUTDOWN;
                        end
                        `SCSD_FAST_FULL_RESET: begin
                            next_c.cfg = `SCSD_CFG0_RST;
                            next_c.qce = `SCSD_QCE_RST;
                            next_c.flags = 3'h0;
                            next_c.flags[`SCSD_FLAG_POR] = 1'b1;
                            next_c.full_reset = 1'b1;
                        end
                        default: begin
                            next_c.cfg = next_c.cfg;
                        end
                    endcase
                end
            end else begin
                next_c.acc.kind = e.cmd[1:0];
                next_c.acc.addr = e.cmd[5:2];
                if (e.cmd[1:0] == `SCSD_TYPE_INCR_WRITE && read_only(e.cmd[5:2])) begin
                    next_c.acc.refused = 1'b1;
                end else begin
                    next_c.acc.start = 1'b1;
                end
            end
        end
        // A new event wins over the clear of the same cycle
        if (events.data_ready) begin
            next_c.flags[`SCSD_FLAG_DR] = 1'b1;
        end
        if (events.checksum_error) begin
            next_c.flags[`SCSD_FLAG_CRC] = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            c <= '0;
            c.cfg <= `SCSD_CFG0_RST;
            c.qce <= `SCSD_QCE_RST;
        end else if (ce) begin
            c <= next_c;
        end
    end

    assign first_config_register = c.cfg;
    assign quick_command_enable = c.qce;
    assign data_ready_flag = c.flags[`SCSD_FLAG_DR];
    assign config_checksum_error_flag = c.flags[`SCSD_FLAG_CRC];
    assign power_on_flag = c.flags[`SCSD_FLAG_POR];
    assign conv_restart = c.conv_restart;
    assign full_reset = c.full_reset;
    assign access = c.acc;

endmodule : scsd_decoder
`default_nettype wire

// File: pkg/scsd_regs.svh
// Constants of the SPI command and status decoder
`ifndef SCSD_REGS_SVH
`define SCSD_REGS_SVH

// ----------------------------------------------------------------
// Command octet layout
// ----------------------------------------------------------------
`define SCSD_CMD_BITS 4'h8
`define SCSD_ADDR_DONE 4'h1
`define SCSD_CMD_LAST 4'h7

// ----------------------------------------------------------------
// Command types
// ----------------------------------------------------------------
`define SCSD_TYPE_FAST 2'h0
`define SCSD_TYPE_STATIC_READ 2'h1
`define SCSD_TYPE_INCR_WRITE 2'h2
`define SCSD_TYPE_INCR_READ 2'h3

// ----------------------------------------------------------------
// Fast command selectors
// ----------------------------------------------------------------
`define SCSD_FAST_CONV_START 4'ha
`define SCSD_FAST_STANDBY 4'hb
`define SCSD_FAST_SHUTDOWN 4'hc
`define SCSD_FAST_FULL_SHUTDOWN 4'hd
`define SCSD_FAST_FULL_RESET 4'he

// ----------------------------------------------------------------
// Conversion mode field values and reset values
// ----------------------------------------------------------------
`define SCSD_MODE_CONVERT 2'h3
`define SCSD_MODE_STANDBY 2'h2
`define SCSD_MODE_SHUTDOWN 2'h0
`define SCSD_CFG0_FULL_SHUTDOWN 8'h00
`define SCSD_CFG0_RST 8'hc0
`define SCSD_QCE_RST 1'b1
`define SCSD_CHIP_ADDR_RST 2'h1

// ----------------------------------------------------------------
// Read-only register addresses and status flag positions
// ----------------------------------------------------------------
`define SCSD_RO_ADDR_FIRST 4'h0
`define SCSD_RO_ADDR_LAST 4'hf
`define SCSD_FLAG_DR 2
`define SCSD_FLAG_CRC 1
`define SCSD_FLAG_POR 0

`endif

// File: pkg/scsd_pkg.sv
// Types of the SPI command and status decoder
package scsd_pkg;

    // Events from the converter core, one-cycle pulses on mclk
    typedef struct packed {
        logic data_ready;
        logic checksum_error;
    } scsd_events_t;

    // Request to the register data engine, mclk domain
    typedef struct packed {
        logic start;
        logic refused;
        logic [1:0] kind;
        logic [3:0] addr;
    } scsd_access_t;

    // Serial side, rising sck, cleared by chip select high
    typedef struct packed {
        logic [3:0] cnt;
        logic [7:0] shift;
        logic hiz;
        logic is_read;
        logic [2:0] snap;
        logic [2:0] fsync1;
        logic [2:0] fsync2;
    } scsd_link_t;

    // Serial side event carrier, survives chip select
    typedef struct packed {
        logic tgl;
        logic [7:0] cmd;
        logic [2:0] snap;
    } scsd_event_t;

    // Serial output, falling sck
    typedef struct packed {
        logic sdo;
        logic oe_n;
    } scsd_out_t;

    // Master clock side
    typedef struct packed {
        logic tsync1;
        logic tsync2;
        logic tsync3;
        logic [2:0] flags;
        logic [7:0] cfg;
        logic qce;
        logic conv_restart;
        logic full_reset;
        scsd_access_t acc;
    } scsd_core_t;

endpackage : scsd_pkg

// File: tb/scsd_props_properties.sv
// Port checks of the command and status decoder
`timescale 1ns/1ps
`default_nettype none
module scsd_props
    import scsd_pkg::*;
#(
    parameter logic [1:0] CHIP_ADDR = 2'h1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sdo_oe_n,
    input wire logic [7:0] first_config_register,
    input wire logic quick_command_enable,
    input wire logic power_on_flag,
    input wire logic conv_restart,
    input wire logic full_reset,
    input wire scsd_access_t access
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_CS_RELEASE: assert property (cs_n |-> sdo_oe_n) else $error("sdo driven while deselected");
    AST_START_MODE: assert property (conv_restart |-> first_config_register[1:0] == 2'h3)
        else $error("start without mode 11");
    AST_START_QCE: assert property (conv_restart |-> $past(quick_command_enable))
        else $error("fast command while disabled");
    AST_START_PULSE: assert property (conv_restart |=> !conv_restart) else $error("start pulse too long");
    AST_FULL_RESET: assert property (full_reset |-> power_on_flag && first_config_register == 8'hc0
        && quick_command_enable) else $error("full reset values wrong");
    AST_FULL_PULSE: assert property (full_reset |=> !full_reset) else $error("reset pulse too long");
    AST_REFUSE: assert property (access.refused |-> access.kind == 2'h2
        && (access.addr == 4'h0 || access.addr == 4'hf)) else $error("bad refusal");
    AST_READ_OK: assert property (access.start && access.kind[0] |-> !access.refused)
        else $error("read refused");
    AST_KIND: assert property (access.start |-> access.kind != 2'h0) else $error("fast code as access");
    AST_POR_SRC: assert property ($rose(power_on_flag) |-> full_reset || $past(full_reset))
        else $error("power-on flag without full reset");
    COV_START: cover property (conv_restart);
    COV_FULL: cover property (full_reset);
    COV_REFUSE: cover property (access.refused);
    COV_READ: cover property (access.start && access.kind == 2'h3);
endmodule : scsd_props
bind scsd_decoder scsd_props #(.CHIP_ADDR(CHIP_ADDR)) u_props (.mclk(mclk), .rst(rst), .cs_n(cs_n),
    .sdo_oe_n(sdo_oe_n), .first_config_register(first_config_register),
    .quick_command_enable(quick_command_enable), .power_on_flag(power_on_flag),
    .conv_restart(conv_restart), .full_reset(full_reset), .access(access));
`default_nettype wire

// File: tb/scsd_host_model.sv
// Behavioural SPI host on the serial pins
`timescale 1ns/1ps
`default_nettype none
module scsd_host_model (
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // Released line reads as the inverse of the last bit
    task automatic xfer(input logic [7:0] cmd, input logic idle, output logic [7:0] rx, output logic oe_n);
        rx = 8'h00;
        sck = idle;
        #7;
        cs_n = 1'b0;
        #24;
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            sdi = cmd[i];
            #24;
            sck = 1'b1;
            rx = {rx[6:0], sdo_oe_n ? ~rx[0] : sdo};
            #24;
        end
        sck = 1'b0;
        #24;
        oe_n = sdo_oe_n;
        sck = idle;
        #7;
        cs_n = 1'b1;
        #48;
    endtask : xfer
endmodule : scsd_host_model
`default_nettype wire

// File: tb/tb_spi_command_status_decoder.sv
// Self-checking bench of the command and status decoder
`timescale 1ns/1ps
`default_nettype none
`define TB_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_spi_command_status_decoder;
    import scsd_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic rdb = 1'b0;
    logic cs_n, sck, sdi, sdo, sdo_oe_n;
    scsd_events_t ev = '0;
    logic cfg_wr = 1'b0;
    logic [7:0] cfg_wr_data = 8'h00;
    logic qce_wr = 1'b0;
    logic qce_wr_data = 1'b0;
    logic [7:0] cfg;
    logic qce, dr_f, crc_f, por_f, conv_restart, full_reset;
    scsd_access_t acc;
    logic [7:0] rx;
    logic oe_n;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int ref_cnt = 0;
    int start_cnt = 0;
    int conv_cnt = 0;
    int full_cnt = 0;
    scsd_host_model host (.cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
    scsd_decoder dut (.mclk(mclk), .rst(rst), .ce(ce), .sck(sck), .cs_n(cs_n), .sdi(sdi),
        .read_data_bit(rdb), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .events(ev), .cfg_wr(cfg_wr),
        .cfg_wr_data(cfg_wr_data), .qce_wr(qce_wr), .qce_wr_data(qce_wr_data),
        .first_config_register(cfg), .quick_command_enable(qce), .data_ready_flag(dr_f),
        .config_checksum_error_flag(crc_f), .power_on_flag(por_f), .conv_restart(conv_restart),
        .full_reset(full_reset), .access(acc));
    initial begin
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (acc.refused === 1'b1) ref_cnt++;
        if (acc.start === 1'b1) start_cnt++;
        if (conv_restart === 1'b1) conv_cnt++;
        if (full_reset === 1'b1) full_cnt++;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic cmd(input logic [7:0] c, input logic idle);
        host.xfer(c, idle, rx, oe_n);
        repeat (8) @(negedge mclk);
    endtask : cmd
    task automatic set_reg(input logic q, input logic [7:0] v);
        @(negedge mclk);
        cfg_wr = !q;
        qce_wr = q;
        cfg_wr_data = v;
        qce_wr_data = v[0];
        @(negedge mclk);
        cfg_wr = 1'b0;
        qce_wr = 1'b0;
    endtask : set_reg
    task automatic t_status;
        `TB_CHK("cfg rst", 8'hc0, cfg)
        `TB_CHK("qce rst", 1'b1, qce)
        `TB_CHK("por rst", 1'b0, por_f)
        cmd(8'h55, 1'b0);
        `TB_CHK("stat", 8'h10, rx)
        `TB_CHK("oe rd", 1'b0, oe_n)
        `TB_CHK("kind", 2'h1, acc.kind)
        `TB_CHK("addr", 4'h5, acc.addr)
        @(negedge mclk);
        ev = '1;
        @(negedge mclk);
        ev = '0;
        `TB_CHK("flags", 2'h3, {dr_f, crc_f})
        cmd(8'h57, 1'b1);
        `TB_CHK("stat ev", 8'h16, rx)
        `TB_CHK("clr", 2'h0, {dr_f, crc_f})
    endtask : t_status
    task automatic t_fast;
        logic [3:0] codes [8] = '{4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'h0, 4'h9, 4'hf};
        logic [7:0] exp;
        int nc;
        int nf;
        nc = conv_cnt;
        nf = full_cnt;
        for (int i = 0; i < 8; i++) begin
            set_reg(1'b0, 8'h55);
            case (codes[i])
                4'ha: exp = 8'h57;
                4'hb: exp = 8'h56;
                4'hc: exp = 8'h54;
                4'hd: exp = 8'h00;
                4'he: exp = 8'hc0;
                default: exp = 8'h55;
            endcase
            cmd({2'h1, codes[i], 2'h0}, i[0]);
            `TB_CHK("cfg fast", exp, cfg)
            `TB_CHK("oe fast", 1'b1, oe_n)
            if (codes[i] == 4'he) `TB_CHK("por", 1'b1, por_f)
            if (codes[i] == 4'h0) `TB_CHK("stat por", 8'h11, rx)
        end
        `TB_CHK("por clr", 1'b0, por_f)
        `TB_CHK("restart pulses", nc + 1, conv_cnt)
        `TB_CHK("full reset pulses", nf + 1, full_cnt)
    endtask : t_fast
    task automatic t_qce_addr;
        set_reg(1'b1, 8'h00);
        set_reg(1'b0, 8'h55);
        cmd(8'h68, 1'b0);
        `TB_CHK("qce off", 8'h55, cfg)
        set_reg(1'b1, 8'h01);
        cmd(8'ha8, 1'b0);
        `TB_CHK("oe miss", 1'b1, oe_n)
        `TB_CHK("cfg miss", 8'h55, cfg)
        cmd(8'h68, 1'b0);
        `TB_CHK("qce on", 8'h57, cfg)
    endtask : t_qce_addr
    task automatic t_access;
        int n;
        int s;
        n = ref_cnt;
        s = start_cnt;
        cmd(8'h7e, 1'b0);
        `TB_CHK("ref ro", n + 1, ref_cnt)
        `TB_CHK("oe wr", 1'b1, oe_n)
        cmd(8'h7f, 1'b0);
        `TB_CHK("ref rd", n + 1, ref_cnt)
        `TB_CHK("rd", 6'h3f, {acc.kind, acc.addr})
        cmd(8'h4e, 1'b0);
        `TB_CHK("ref wr", n + 1, ref_cnt)
        `TB_CHK("wr", 6'h23, {acc.kind, acc.addr})
        `TB_CHK("starts", s + 2, start_cnt)
    endtask : t_access
    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        repeat (2) @(negedge mclk);
        t_status();
        t_fast();
        t_qce_addr();
        t_access();
        give_verdict();
    end
endmodule : tb_spi_command_status_decoder
`default_nettype wire
